//--- timer_conflict_priority.sv
// Timer unit with same-cycle conflict arbitration between software and timer events.
// Assumes a register port with one-cycle strobes and read data one cycle later.
//
// Operation
// - Reload and write to destination together: the write is stored, the reload dropped.
// - Write to reload source during reload: old value moves, source takes the write.
// - Counter write beats a count step; counting resumes from the written value.
// - Count step together with clear leaves the counter at one.
// - Event counter A clears by compare only in modes 000, 110 and 111.
// - Event counter B clears by compare only in mode 001.
// - Counter write coinciding with overflow stores the write and still sets overflow.
// - Write one cycle before the overflowing step prevents the overflow flag.
// - Overflow flag clear by writing zero wins over a same-cycle overflow.
// - Overflow is the wrap from all ones to zero and raises the flag.
// - A flag just cleared can be set again by an overflow next cycle.
// - Compare at maximum with clearing on clears the counter without overflow.
// - Without clear by compare, the wrap sets the overflow flag.
// - Noise counter write in the match cycle suppresses match and capture.
// - Noise compare write in the match cycle suppresses match and capture.
// - Noise write one cycle after the match leaves match and capture intact.
// - Counter write beats clear by compare, yet the compare flag is set.
//
// The placing of the registers and strobed register access are this design's own decisions.

`include "timer_conflict_regs.svh"

module timer_conflict_priority
	import timer_conflict_pkg::*;
(
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            rstn,
	// Register port
	input  timer_conflict_pkg::regReq_type       busReq,
	output logic           [`DATA_WIDTH-1:0]     rdata_q,
	// Timer inputs
	input  wire logic                            eventA,
	input  wire logic                            eventB,
	input  wire logic                            noiseIn,
	// Timer outputs
	output logic                                 pwmOut_q,
	output logic                                 noiseLevel_q
);
	import timer_conflict_pkg::*;

	// Control fields
	logic                         pwmClearEnable_q;
	eventMode_type                eventMode_q;
	prescale_type                 prescale_q;
	logic [`LANES-1:0]            laneEnable_q;
	logic                         pwmOutEnable_q;

	// Prescaler
	logic [`PRE_WIDTH-1:0]        preCount_q;
	logic                         tick;

	// Lane wiring
	logic [`LANES-1:0]            laneStep;
	logic [`LANES-1:0]            laneClearEnable;
	logic [`LANES-1:0]            laneWrite;
	logic [`LANES-1:0]            laneOvf;
	logic [`LANES-1:0]            laneCmpFlag;
	logic [`LANES-1:0]            laneMatch;
	logic [`WIDE_WIDTH-1:0]       laneCmp   [`LANES];
	logic [`WIDE_WIDTH-1:0]       laneCount [`LANES];
	logic [`WIDE_WIDTH-1:0]       cmpReg_q  [`CMP_LANES];
	logic                         statusWrite;

	// Cycle and duty registers
	logic [`NARROW_WIDTH-1:0]     cycle_q;
	logic [`NARROW_WIDTH-1:0]     cycleReload_q;
	logic [`NARROW_WIDTH-1:0]     duty_q;
	logic [`NARROW_WIDTH-1:0]     dutyReload_q;

	// Noise filter and capture
	logic [`NOISE_WIDTH-1:0]      noiseCount;
	logic [`NOISE_WIDTH-1:0]      noiseCompare;
	logic                         noiseCapture;
	logic [`WIDE_WIDTH-1:0]       capture_q;
	logic                         noiseFlag_q;

	logic [`DATA_WIDTH-1:0]       readData;

	// Decoded register writes
	logic                         cycleWrite;
	logic                         cycleReloadWrite;
	logic                         dutyWrite;
	logic                         dutyReloadWrite;
	logic                         noiseCntWrite;
	logic                         noiseCmpWrite;

	function automatic logic regWrite(input regReq_type req, input logic [7:0] offset);
		return req.wr && (req.addr == offset);
	endfunction : regWrite

	function automatic logic [7:0] cntOffset(input int lane);
		return 8'(`OFF_CNT0 + lane * `LANE_STRIDE);
	endfunction : cntOffset

	function automatic logic [7:0] cmpOffset(input int lane);
		return 8'(`OFF_CMP0 + lane * `LANE_STRIDE);
	endfunction : cmpOffset

	// Clear by compare is tied to the event timer mode per counter
	function automatic logic modeClears(input eventMode_type mode, input logic counterB);
		if (counterB) begin
			return mode == 3'b001;
		end
		return (mode == 3'b000) || (mode == 3'b110) || (mode == 3'b111);
	endfunction : modeClears

	// One status write clears every flag whose bit is written 0, except a capture flag set by a capture in that cycle
	assign statusWrite      = regWrite(busReq, `OFF_STATUS);
	assign cycleWrite       = regWrite(busReq, `OFF_CYCLE);
	assign cycleReloadWrite = regWrite(busReq, `OFF_CYCLE_RLD);
	assign dutyWrite        = regWrite(busReq, `OFF_DUTY);
	assign dutyReloadWrite  = regWrite(busReq, `OFF_DUTY_RLD);
	assign noiseCntWrite    = regWrite(busReq, `OFF_NOISE_CNT);
	assign noiseCmpWrite    = regWrite(busReq, `OFF_NOISE_CMP);

	// Control register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwmClearEnable_q <= 1'b0;
			eventMode_q      <= 3'b000;
			prescale_q       <= 2'b00;
			laneEnable_q     <= '0;
			pwmOutEnable_q   <= 1'b0;
		end else if (regWrite(busReq, `OFF_CTRL)) begin
			pwmClearEnable_q <= busReq.wdata[`CTRL_PWM_CLR];
			eventMode_q      <= busReq.wdata[`CTRL_MODE_LO +: 3];
			prescale_q       <= busReq.wdata[`CTRL_PRE_LO +: 2];
			laneEnable_q     <= busReq.wdata[`CTRL_EN_LO +: `LANES];
			pwmOutEnable_q   <= busReq.wdata[`CTRL_PWM_OUT];
		end
	end

	// Free-running prescaler; a tick every 1, 2, 4 or 8 clocks
	// Not restarted by a rate change, so the first tick after one may come early
	always_ff @(posedge clk) begin
		if (!rstn) begin
			preCount_q <= '0;
		end else begin
			preCount_q <= preCount_q + `PRE_WIDTH'(1);
		end
	end

	always_comb begin
		case (prescale_q)
			2'b00:   tick = 1'b1;
			2'b01:   tick = preCount_q[0] == 1'b0;
			2'b10:   tick = preCount_q[1:0] == 2'b00;
			default: tick = preCount_q == 3'b000;
		endcase
	end

	// Step sources and clear-enable selection per lane
	always_comb begin
		laneStep[0]        = laneEnable_q[0] && tick;
		laneStep[1]        = laneEnable_q[1] && eventA;
		laneStep[2]        = laneEnable_q[2] && eventB;
		laneStep[3]        = laneEnable_q[3] && tick;
		laneStep[4]        = laneEnable_q[4] && tick;
		laneClearEnable[0] = pwmClearEnable_q;
		laneClearEnable[1] = modeClears(eventMode_q, 1'b0);
		laneClearEnable[2] = modeClears(eventMode_q, 1'b1);
		laneClearEnable[3] = 1'b1;
		laneClearEnable[4] = 1'b1;
	end

	// Compare registers of the first four lanes; the PWM lane compares with cycle
	for (genvar i = 0; i < `CMP_LANES; i++) begin : g_cmp
		always_ff @(posedge clk) begin
			if (!rstn) begin
				cmpReg_q[i] <= `CMP_RESET;
			end else if (regWrite(busReq, cmpOffset(i))) begin
				cmpReg_q[i] <= busReq.wdata[`WIDE_WIDTH-1:0];
			end
		end
		assign laneCmp[i] = cmpReg_q[i];
	end
	assign laneCmp[`LANE_PWM] = {8'h00, cycle_q};

	for (genvar i = 0; i < `LANES; i++) begin : g_lane
		localparam int W = (i >= `NARROW_FIRST) ? `NARROW_WIDTH : `WIDE_WIDTH;
		logic [W-1:0] count;

		assign laneWrite[i] = regWrite(busReq, cntOffset(i));

		timer_count_lane #(
			.WIDTH(W)
		) u_lane (
			.clk          (clk),
			.rstn         (rstn),
			.countStep    (laneStep[i]),
			.clearEnable  (laneClearEnable[i]),
			.cmpValue     (laneCmp[i][W-1:0]),
			.cntWrite     (laneWrite[i]),
			.cntWdata     (busReq.wdata[W-1:0]),
			.flagWrite    (statusWrite),
			.ovfKeep      (busReq.wdata[`ST_OVF_LO + i]),
			.cmpKeep      (busReq.wdata[`ST_CMP_LO + i]),
			.count_q      (count),
			.ovfFlag_q    (laneOvf[i]),
			.cmpFlag_q    (laneCmpFlag[i]),
			.matchPulse_q (laneMatch[i])
		);

		// Narrow lanes are zero-extended so the read mux sees one width
		if (W < `WIDE_WIDTH) begin : g_pad
			assign laneCount[i] = {{(`WIDE_WIDTH - W){1'b0}}, count};
		end else begin : g_full
			assign laneCount[i] = count;
		end
	end

	// Reload on cycle match; a write to the destination in that cycle wins,
	// and a write to the source still lets the old source value move
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cycle_q <= `CYCLE_RESET;
		end else if (cycleWrite) begin
			cycle_q <= busReq.wdata[`NARROW_WIDTH-1:0];
		end else if (laneMatch[`LANE_PWM]) begin
			cycle_q <= cycleReload_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			duty_q <= `DUTY_RESET;
		end else if (dutyWrite) begin
			duty_q <= busReq.wdata[`NARROW_WIDTH-1:0];
		end else if (laneMatch[`LANE_PWM]) begin
			duty_q <= dutyReload_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cycleReload_q <= `CYCLE_RESET;
			dutyReload_q  <= `DUTY_RESET;
		end else begin
			if (cycleReloadWrite) begin
				cycleReload_q <= busReq.wdata[`NARROW_WIDTH-1:0];
			end
			if (dutyReloadWrite) begin
				dutyReload_q <= busReq.wdata[`NARROW_WIDTH-1:0];
			end
		end
	end

	// Output high while the PWM counter is below the duty value
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwmOut_q <= 1'b0;
		end else begin
			pwmOut_q <= pwmOutEnable_q && (laneCount[`LANE_PWM][`NARROW_WIDTH-1:0] < duty_q);
		end
	end

	noise_filter_lane u_noise (
		.clk            (clk),
		.rstn           (rstn),
		.rawIn          (noiseIn),
		.cntWrite       (noiseCntWrite),
		.cmpWrite       (noiseCmpWrite),
		.wdata          (busReq.wdata[`NOISE_WIDTH-1:0]),
		.noiseCount_q   (noiseCount),
		.noiseCompare_q (noiseCompare),
		.level_q        (noiseLevel_q),
		.capture_q      (noiseCapture)
	);

	// Input capture of the capture channel counter on a filtered edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			capture_q <= '0;
		end else if (noiseCapture) begin
			capture_q <= laneCount[`LANE_CAPTURE];
		end
	end

	// Capture flag: unlike the timer flags, a new capture beats the clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			noiseFlag_q <= 1'b0;
		end else if (noiseCapture) begin
			noiseFlag_q <= 1'b1;
		end else if (statusWrite && !busReq.wdata[`ST_NOISE]) begin
			noiseFlag_q <= 1'b0;
		end
	end

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		readData = '0;
		if (busReq.addr == `OFF_CTRL) begin
			readData[`CTRL_PWM_CLR]              = pwmClearEnable_q;
			readData[`CTRL_MODE_LO +: 3]         = eventMode_q;
			readData[`CTRL_PRE_LO +: 2]          = prescale_q;
			readData[`CTRL_EN_LO +: `LANES]      = laneEnable_q;
			readData[`CTRL_PWM_OUT]              = pwmOutEnable_q;
		end
		if (busReq.addr == `OFF_STATUS) begin
			readData[`ST_OVF_LO +: `LANES] = laneOvf;
			readData[`ST_CMP_LO +: `LANES] = laneCmpFlag;
			readData[`ST_NOISE]            = noiseFlag_q;
		end
		for (int i = 0; i < `LANES; i++) begin
			if (busReq.addr == cntOffset(i)) begin
				readData = {8'h00, laneCount[i]};
			end
		end
		for (int i = 0; i < `CMP_LANES; i++) begin
			if (busReq.addr == cmpOffset(i)) begin
				readData = {8'h00, cmpReg_q[i]};
			end
		end
		case (busReq.addr)
			`OFF_CYCLE:     readData = {16'h0000, cycle_q};
			`OFF_CYCLE_RLD: readData = {16'h0000, cycleReload_q};
			`OFF_DUTY:      readData = {16'h0000, duty_q};
			`OFF_DUTY_RLD:  readData = {16'h0000, dutyReload_q};
			`OFF_NOISE_CNT: readData = {24'h000000, noiseCount};
			`OFF_NOISE_CMP: readData = {24'h000000, noiseCompare};
			`OFF_CAPTURE:   readData = {8'h00, capture_q};
			default:        readData = readData;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= busReq.rd ? readData : '0;
		end
	end
endmodule : timer_conflict_priority

//--- timer_conflict_regs.svh
// Register offsets, field positions, reset values and widths of the timer conflict block.
// Assumes byte addresses on an 8-bit register port with 32-bit words.
`ifndef TIMER_CONFLICT_REGS_SVH
`define TIMER_CONFLICT_REGS_SVH

`define ADDR_WIDTH      8
`define DATA_WIDTH      32
`define WIDE_WIDTH      24
`define NARROW_WIDTH    16
`define NOISE_WIDTH     8
`define LANES           5
`define NARROW_FIRST    3
`define CMP_LANES       4
`define LANE_CAPTURE    0
`define LANE_PWM        4

`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_CNT0        8'h08
`define OFF_CMP0        8'h0c
`define LANE_STRIDE     8'h08
`define OFF_CYCLE       8'h2c
`define OFF_CYCLE_RLD   8'h30
`define OFF_DUTY        8'h34
`define OFF_DUTY_RLD    8'h38
`define OFF_NOISE_CNT   8'h3c
`define OFF_NOISE_CMP   8'h40
`define OFF_CAPTURE     8'h44

`define CTRL_PWM_CLR    0
`define CTRL_MODE_LO    1
`define CTRL_PRE_LO     4
`define CTRL_EN_LO      8
`define CTRL_PWM_OUT    13

`define ST_OVF_LO       0
`define ST_CMP_LO       8
`define ST_NOISE        16

`define CMP_RESET       24'hffffff
`define CYCLE_RESET     16'hffff
`define DUTY_RESET      16'h0000
`define NOISE_RESET     8'h0f
`define PRE_WIDTH       3

`endif

//--- timer_conflict_pkg.sv
// Types shared by the timer conflict block.
// Assumes the constants header is included by every user.
package timer_conflict_pkg;
	`include "timer_conflict_regs.svh"

	typedef struct packed {
		logic [`ADDR_WIDTH-1:0] addr;
		logic [`DATA_WIDTH-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} regReq_type;

	typedef logic [2:0] eventMode_type;

	typedef logic [1:0] prescale_type;
endpackage : timer_conflict_pkg

//--- timer_count_lane.sv
// One up-counter with software write, clear by compare match and overflow flag.
// Assumes strobes synchronous to clk and one cycle wide.
module timer_count_lane #(
	parameter int WIDTH = 24
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// Counting control
	input  wire logic             countStep,
	input  wire logic             clearEnable,
	input  wire logic [WIDTH-1:0] cmpValue,
	// Software access
	input  wire logic             cntWrite,
	input  wire logic [WIDTH-1:0] cntWdata,
	input  wire logic             flagWrite,
	input  wire logic             ovfKeep,
	input  wire logic             cmpKeep,
	// State
	output logic      [WIDTH-1:0] count_q,
	output logic                  ovfFlag_q,
	output logic                  cmpFlag_q,
	output logic                  matchPulse_q
);
	localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};
	localparam logic [WIDTH-1:0] ONE_COUNT = {{(WIDTH-1){1'b0}}, 1'b1};

	logic [WIDTH-1:0] count_d;
	logic             clearNow;
	logic             wrapNow;

	// Match is seen in the same cycle that the counter holds the compare value
	assign clearNow = clearEnable && matchPulse_q;
	// With clearing on and compare at maximum the clear pre-empts the wrap
	assign wrapNow = countStep && (count_q == MAX_COUNT) && !clearNow
		&& !(clearEnable && (count_q == cmpValue));

	always_comb begin
		if (cntWrite) begin
			count_d = cntWdata;
		end else if (clearNow && countStep) begin
			count_d = ONE_COUNT;
		end else if (clearNow) begin
			count_d = '0;
		end else if (countStep) begin
			count_d = count_q + ONE_COUNT;
		end else begin
			count_d = count_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			matchPulse_q <= 1'b0;
		end else begin
			matchPulse_q <= countStep && !cntWrite && (count_d == cmpValue);
		end
	end

	// Overflow flag: set even when a write lands on the wrap; write 0 wins
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ovfFlag_q <= 1'b0;
		end else if (flagWrite && !ovfKeep) begin
			ovfFlag_q <= 1'b0;
		end else if (wrapNow) begin
			ovfFlag_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmpFlag_q <= 1'b0;
		end else if (flagWrite && !cmpKeep) begin
			cmpFlag_q <= 1'b0;
		end else if (matchPulse_q) begin
			cmpFlag_q <= 1'b1;
		end
	end
endmodule : timer_count_lane

//--- noise_filter_lane.sv
// Noise filter: input must hold a new level for the compare count before capture.
// Assumes rawIn is already synchronous to clk.
`include "timer_conflict_regs.svh"
module noise_filter_lane (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rstn,
	// Filtered input
	input  wire logic                    rawIn,
	// Software access
	input  wire logic                    cntWrite,
	input  wire logic                    cmpWrite,
	input  wire logic [`NOISE_WIDTH-1:0] wdata,
	// State
	output logic      [`NOISE_WIDTH-1:0] noiseCount_q,
	output logic      [`NOISE_WIDTH-1:0] noiseCompare_q,
	output logic                         level_q,
	output logic                         capture_q
);
	logic differs;
	logic matchNow;

	assign differs = rawIn != level_q;
	// A write to either side in the match cycle removes the match entirely
	assign matchNow = differs && (noiseCount_q == noiseCompare_q)
		&& !cntWrite && !cmpWrite;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			noiseCount_q <= '0;
		end else if (cntWrite) begin
			noiseCount_q <= wdata;
		end else if (matchNow || !differs) begin
			noiseCount_q <= '0;
		end else begin
			noiseCount_q <= noiseCount_q + `NOISE_WIDTH'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			noiseCompare_q <= `NOISE_RESET;
		end else if (cmpWrite) begin
			noiseCompare_q <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			level_q   <= 1'b0;
			capture_q <= 1'b0;
		end else begin
			level_q   <= matchNow ? rawIn : level_q;
			capture_q <= matchNow;
		end
	end
endmodule : noise_filter_lane

//--- timer_conflict_priority_asserts.sv
// Port-level checker for the timer conflict block.
// Assumes the package and constants header are compiled before this file.
`include "timer_conflict_regs.svh"
module timer_conflict_priority_asserts
	import timer_conflict_pkg::*;
(
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       rstn,
	// Register port
	input timer_conflict_pkg::regReq_type  busReq,
	input wire logic [`DATA_WIDTH-1:0]     rdata_q,
	// Timer pins
	input wire logic                       eventA,
	input wire logic                       eventB,
	input wire logic                       noiseIn,
	input wire logic                       pwmOut_q,
	input wire logic                       noiseLevel_q
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Last written PWM output enable, seen from the register port only
	logic pwmEn_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwmEn_q <= 1'b0;
		end else if (busReq.wr && busReq.addr == `OFF_CTRL) begin
			pwmEn_q <= busReq.wdata[`CTRL_PWM_OUT];
		end
	end

	a_rdata_idle_zero: assert property (!busReq.rd |=> rdata_q == '0)
		else $error("read data not zero outside a read answer");
	a_unmapped_read_zero: assert property (
		(busReq.rd && busReq.addr > `OFF_CAPTURE) |=> rdata_q == '0)
		else $error("unmapped read returned data");
	a_narrow_upper_zero: assert property (
		(busReq.rd && busReq.addr == `OFF_NOISE_CMP) |=> rdata_q[`DATA_WIDTH-1:`NOISE_WIDTH] == '0)
		else $error("noise compare read has upper bits set");
	a_noise_cnt_write: assert property (
		(busReq.wr && busReq.addr == `OFF_NOISE_CNT) |=> $stable(noiseLevel_q))
		else $error("filtered level moved on a noise counter write");
	a_noise_cmp_write: assert property (
		(busReq.wr && busReq.addr == `OFF_NOISE_CMP) |=> $stable(noiseLevel_q))
		else $error("filtered level moved on a noise compare write");
	a_level_follows_input: assert property (
		$changed(noiseLevel_q) |-> noiseLevel_q == $past(noiseIn))
		else $error("filtered level differs from the sampled input");
	a_level_needs_change: assert property (
		noiseIn == noiseLevel_q |=> $stable(noiseLevel_q))
		else $error("filtered level moved without an input change");
	a_pwm_off_disabled: assert property (
		(!pwmEn_q && !$past(pwmEn_q)) |-> !pwmOut_q)
		else $error("pwm output high while disabled");

	c_read_answer: cover property (busReq.rd ##1 rdata_q != '0);
	c_level_rise: cover property ($rose(noiseLevel_q));
	c_pwm_high: cover property ($rose(pwmOut_q));
endmodule : timer_conflict_priority_asserts

bind timer_conflict_priority timer_conflict_priority_asserts u_asserts (
	.clk          (clk),
	.rstn         (rstn),
	.busReq       (busReq),
	.rdata_q      (rdata_q),
	.eventA       (eventA),
	.eventB       (eventB),
	.noiseIn      (noiseIn),
	.pwmOut_q     (pwmOut_q),
	.noiseLevel_q (noiseLevel_q)
);

//--- timer_conflict_priority_tb.sv
// Self-checking bench for the timer conflict block.
// Assumes the package, constants header and checker are compiled first.
`include "timer_conflict_regs.svh"
module timer_conflict_priority_tb
	import timer_conflict_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [7:0] cntCap = `OFF_CNT0;
	localparam logic [7:0] cmpCap = `OFF_CMP0;
	localparam logic [7:0] cntA   = 8'h10;
	localparam logic [7:0] cmpA   = 8'h14;
	localparam logic [7:0] cntB   = 8'h18;
	localparam logic [7:0] cmpB   = 8'h1c;
	localparam logic [7:0] cntPwm = 8'h28;

	logic        clk, rstn, eventA, eventB, noiseIn, pwmOut_q, noiseLevel_q, rdSeen;
	regReq_type  busReq;
	logic [31:0] rdata_q, rdExp, rdMask, expQ, maskQ;
	string       rdName, nameQ;
	int          failures, total_checks, cycles;
	logic [7:0]  rstAddr [9] = '{`OFF_CTRL, `OFF_STATUS, `OFF_CMP0, `OFF_CYCLE, `OFF_CYCLE_RLD,
		`OFF_DUTY, `OFF_NOISE_CMP, 8'h48, `OFF_CAPTURE};
	logic [31:0] rstVal [9] = '{32'h0, 32'h0, 32'hffffff, 32'hffff, 32'hffff, 32'h0, 32'hf,
		32'h0, 32'h0};

	timer_conflict_priority dut (.clk(clk), .rstn(rstn), .busReq(busReq), .rdata_q(rdata_q),
		.eventA(eventA), .eventB(eventB), .noiseIn(noiseIn), .pwmOut_q(pwmOut_q),
		.noiseLevel_q(noiseLevel_q));

	always #2 clk = ~clk;

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
	endtask : wr_reg

	// Expectation travels with the strobe; the answer is compared a half cycle later
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input string n);
		busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		rdExp <= e;
		rdMask <= m;
		rdName <= n;
		@(posedge clk);
	endtask : rd_reg

	task automatic idle(input int n);
		busReq <= '0;
		repeat (n) @(posedge clk);
	endtask : idle

	task automatic chk_level(input logic e);
		busReq <= '0;
		@(negedge clk);
		check("filtered level", {31'h0, noiseLevel_q}, {31'h0, e});
		@(posedge clk);
	endtask : chk_level

	task automatic chk_pwm(input logic e);
		busReq <= '0;
		@(negedge clk);
		check("pwm output", {31'h0, pwmOut_q}, {31'h0, e});
		@(posedge clk);
	endtask : chk_pwm

	// Overflow on event counter A, which never clears by compare in mode 001
	// Kind 1 clears a set flag one cycle before the wrap, kind 2 in the wrap cycle
	task automatic ovf_case(input int kind, input logic [31:0] flag, input logic [31:0] cnt);
		if (kind == 0 || kind > 2) wr_reg(`OFF_STATUS, 32'h0);
		wr_reg(cntA, 32'hffffff);
		if (kind == 4) wr_reg(cntA, 32'h10);
		if (kind == 1) wr_reg(`OFF_STATUS, 32'h0);
		eventA <= 1'b1;
		case (kind)
			2: wr_reg(`OFF_STATUS, 32'h0);
			3: wr_reg(cntA, 32'h10);
			default: idle(1);
		endcase
		eventA <= 1'b0;
		idle(2);
		rd_reg(`OFF_STATUS, flag, 32'h2, "overflow flag");
		rd_reg(cntA, cnt, 32'hffffff, "event A count");
		$display("test overflow case %0d done", kind);
	endtask : ovf_case

	always @(posedge clk) begin
		rdSeen <= busReq.rd;
		expQ <= rdExp;
		maskQ <= rdMask;
		nameQ <= rdName;
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_sim();
		end
	end

	always @(negedge clk) begin
		if (rdSeen === 1'b1) check(nameQ, rdata_q & maskQ, expQ);
	end

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		busReq = '0;
		eventA = 1'b0;
		eventB = 1'b0;
		noiseIn = 1'b0;
		rdExp = '0;
		rdMask = '0;
		failures = 0;
		total_checks = 0;
		cycles = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		wr_reg(8'h48, 32'hffffffff);
		wr_reg(`OFF_CAPTURE, 32'hffffffff);
		foreach (rstAddr[i]) rd_reg(rstAddr[i], rstVal[i], 32'hffffffff, "reset value");
		$display("test reset values done");
		wr_reg(cmpA, 32'h5);
		wr_reg(cmpB, 32'h5);
		for (int m = 0; m < 8; m++) begin
			wr_reg(`OFF_CTRL, 32'h600 | 32'(m << 1));
			wr_reg(cntA, 32'h3);
			wr_reg(cntB, 32'h3);
			eventA <= 1'b1;
			eventB <= 1'b1;
			idle(3);
			eventA <= 1'b0;
			eventB <= 1'b0;
			rd_reg(cntA, (m == 0 || m >= 6) ? 32'h1 : 32'h6, 32'hffffff, "count A");
			rd_reg(cntB, (m == 1) ? 32'h1 : 32'h6, 32'hffffff, "count B");
		end
		$display("test event modes done");
		wr_reg(`OFF_CTRL, 32'h200);
		wr_reg(`OFF_STATUS, 32'h0);
		wr_reg(cntA, 32'h4);
		eventA <= 1'b1;
		idle(1);
		eventA <= 1'b0;
		wr_reg(cntA, 32'h20);
		rd_reg(cntA, 32'h20, 32'hffffff, "count A");
		rd_reg(`OFF_STATUS, 32'h200, 32'h200, "compare flag");
		wr_reg(cmpA, 32'hffffff);
		wr_reg(`OFF_STATUS, 32'h0);
		wr_reg(cntA, 32'hfffffe);
		eventA <= 1'b1;
		idle(2);
		eventA <= 1'b0;
		idle(2);
		rd_reg(`OFF_STATUS, 32'h0, 32'h2, "overflow flag");
		rd_reg(cntA, 32'h1, 32'hffffff, "count A");
		eventA <= 1'b1;
		wr_reg(cntA, 32'h100);
		eventA <= 1'b0;
		rd_reg(cntA, 32'h100, 32'hffffff, "count A");
		eventA <= 1'b1;
		idle(1);
		eventA <= 1'b0;
		rd_reg(cntA, 32'h101, 32'hffffff, "count A");
		$display("test write against count done");
		wr_reg(`OFF_CTRL, 32'h202);
		ovf_case(0, 32'h2, 32'h0);
		ovf_case(1, 32'h2, 32'h0);
		ovf_case(2, 32'h0, 32'h0);
		ovf_case(3, 32'h2, 32'h10);
		ovf_case(4, 32'h0, 32'h11);
		wr_reg(cmpCap, 32'h3);
		wr_reg(`OFF_CTRL, 32'h101);
		idle(20);
		wr_reg(`OFF_CTRL, 32'h0);
		rd_reg(cntCap, 32'h0, 32'hfffffc, "capture count");
		wr_reg(`OFF_CTRL, 32'h100);
		wr_reg(cntCap, 32'h0);
		idle(10);
		wr_reg(`OFF_CTRL, 32'h0);
		rd_reg(cntCap, 32'h8, 32'hfffff8, "capture count");
		wr_reg(`OFF_CTRL, 32'h830);
		wr_reg(8'h20, 32'h0);
		idle(32);
		wr_reg(`OFF_CTRL, 32'h0);
		rd_reg(8'h20, 32'h4, 32'hfffffe, "interval count");
		$display("test capture clear enable done");
		wr_reg(`OFF_DUTY_RLD, 32'h55);
		wr_reg(`OFF_CYCLE_RLD, 32'h1234);
		wr_reg(`OFF_CTRL, 32'h3000);
		wr_reg(cntPwm, 32'hfffe);
		idle(1);
		wr_reg(`OFF_CYCLE_RLD, 32'h777);
		rd_reg(`OFF_CYCLE, 32'h1234, 32'hffffffff, "cycle");
		rd_reg(`OFF_CYCLE_RLD, 32'h777, 32'hffffffff, "cycle reload");
		rd_reg(`OFF_DUTY, 32'h55, 32'hffffffff, "duty");
		wr_reg(cntPwm, 32'h1233);
		idle(1);
		wr_reg(`OFF_CYCLE, 32'h999);
		rd_reg(`OFF_CYCLE, 32'h999, 32'hffffffff, "cycle");
		wr_reg(cntPwm, 32'h10);
		idle(1);
		chk_pwm(1'b1);
		wr_reg(cntPwm, 32'h100);
		idle(1);
		chk_pwm(1'b0);
		wr_reg(`OFF_CTRL, 32'h0);
		$display("test reload conflicts done");
		wr_reg(`OFF_STATUS, 32'h0);
		noiseIn <= 1'b1;
		repeat (20) wr_reg(`OFF_NOISE_CNT, 32'hf);
		chk_level(1'b0);
		wr_reg(`OFF_NOISE_CNT, 32'h0);
		chk_level(1'b1);
		rd_reg(`OFF_STATUS, 32'h10000, 32'h10000, "capture flag");
		rd_reg(`OFF_CAPTURE, 32'hb, 32'hffffffff, "capture value");
		noiseIn <= 1'b0;
		repeat (40) wr_reg(`OFF_NOISE_CMP, 32'hf);
		chk_level(1'b1);
		$display("test noise filter done");
		idle(2);
		end_sim();
	end
endmodule : timer_conflict_priority_tb
